// ===== verilog/gmp_consts.svh
`ifndef GMP_CONSTS_SVH
`define GMP_CONSTS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define GMP_REF_CLK_NS     25
`define GMP_LINK_HALF_NS   200
`define GMP_LINK_HALF_CYC  (`GMP_LINK_HALF_NS / `GMP_REF_CLK_NS)
`define GMP_DIV_W          4
`define GMP_DIV_LAST       4'(`GMP_LINK_HALF_CYC - 1)

// ----------------------------------------------------------------------------
// widths and values
// ----------------------------------------------------------------------------
`define GMP_BYTE_W         8
`define GMP_PAIR_N         4
`define GMP_NIBBLE_MASK    8'h0F
`define GMP_PAIRS_ALL      4'hF
`define GMP_PAIRS_NONE     4'h0
`define GMP_PAIR_FIRST     4'h1
`define GMP_PAIR_SECOND    4'h2

// ----------------------------------------------------------------------------
// synchroniser bit positions, device end: {gtx_clk, tx_er, tx_en, txd}
// ----------------------------------------------------------------------------
`define GMP_PHY_SYN_W      11
`define GMP_PHY_GTX_BIT    10
`define GMP_PHY_TXER_BIT   9
`define GMP_PHY_TXEN_BIT   8

// ----------------------------------------------------------------------------
// synchroniser bit positions, mac end: {rx_clk, tx_clk, crs, col, rx_er, rx_dv, rxd}
// ----------------------------------------------------------------------------
`define GMP_MAC_SYN_W      14
`define GMP_MAC_RXCLK_BIT  13
`define GMP_MAC_TXCLK_BIT  12
`define GMP_MAC_CRS_BIT    11
`define GMP_MAC_COL_BIT    10
`define GMP_MAC_RXER_BIT   9
`define GMP_MAC_RXDV_BIT   8

`endif

// ===== verilog/gmp_pkg.sv
`default_nettype none

`include "gmp_consts.svh"

package gmp_pkg;

  typedef logic [`GMP_BYTE_W-1:0]    gmp_byte_t;
  typedef logic [`GMP_PAIR_N-1:0]    gmp_pairs_t;
  typedef logic [`GMP_DIV_W-1:0]     gmp_div_t;
  typedef logic [`GMP_PHY_SYN_W-1:0] gmp_phy_syn_t;
  typedef logic [`GMP_MAC_SYN_W-1:0] gmp_mac_syn_t;

  typedef struct packed {
    gmp_phy_syn_t syn1;
    gmp_phy_syn_t syn2;
    gmp_phy_syn_t syn3;
    gmp_phy_syn_t filt;
    logic         gtx_prev;
    gmp_div_t     div_cnt;
    logic         tx_clk;
    logic         rx_clk;
    gmp_byte_t    rxd;
    logic         rx_dv;
    logic         rx_er;
    logic         crs;
    logic         col;
    logic         rx_strobe;
    logic         tx_in_frame;
    gmp_byte_t    tx_data;
    logic         tx_valid;
    logic         tx_error;
    logic         tx_sof;
    logic         tx_eof;
    logic         lpi_req;
    gmp_pairs_t   pair_tx;
    gmp_pairs_t   pair_rx;
  } gmp_phy_st_t;

  typedef struct packed {
    gmp_mac_syn_t syn1;
    gmp_mac_syn_t syn2;
    gmp_mac_syn_t syn3;
    gmp_mac_syn_t filt;
    logic         rxc_prev;
    logic         txc_prev;
    gmp_div_t     div_cnt;
    logic         gtx_clk;
    gmp_byte_t    txd;
    logic         tx_en;
    logic         tx_er;
    logic         tx_strobe;
    gmp_byte_t    rx_data;
    logic         rx_valid;
    logic         rx_error;
    logic         partner_lpi;
    logic         carrier;
    logic         collision;
  } gmp_mac_st_t;

  // low nibble only in mii mode, upper bits forced low
  function automatic gmp_byte_t gmp_lane(input logic gmii, input gmp_byte_t d);
    return gmii ? d : (d & `GMP_NIBBLE_MASK);
  endfunction

  function automatic logic gmp_div_wrap(input gmp_div_t c);
    return c == `GMP_DIV_LAST;
  endfunction

  // change of a synchronised bit counts once stages two and three agree
  function automatic gmp_mac_syn_t gmp_filt(input gmp_mac_syn_t s2, input gmp_mac_syn_t s3,
                                            input gmp_mac_syn_t f);
    return (s2 & ~(s2 ^ s3)) | (f & (s2 ^ s3));
  endfunction

endpackage

`default_nettype wire

// ===== verilog/gmp_link_if.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmp_consts.svh"

interface gmp_link_if;
  logic [`GMP_BYTE_W-1:0] txd;
  logic                   tx_en;
  logic                   tx_er;
  logic                   gtx_clk;
  logic                   tx_clk;
  logic                   col;
  logic                   crs;
  logic [`GMP_BYTE_W-1:0] rxd;
  logic                   rx_dv;
  logic                   rx_er;
  logic                   rx_clk;

  modport phy (
    input  txd, tx_en, tx_er, gtx_clk,
    output tx_clk, col, crs, rxd, rx_dv, rx_er, rx_clk
  );

  modport mac (
    output txd, tx_en, tx_er, gtx_clk,
    input  tx_clk, col, crs, rxd, rx_dv, rx_er, rx_clk
  );
endinterface

`default_nettype wire

// ===== verilog/gmp_mac_end.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmp_consts.svh"

module gmp_mac_end
  import gmp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // link toward the device
  gmp_link_if.mac         link,
  // mode
  input  wire logic       gmii_mode,
  // transmit stream from the user
  input  wire logic       frame_valid,
  input  wire gmp_byte_t  frame_data,
  input  wire logic       frame_err,
  input  wire logic       lpi_request,
  output logic            tx_strobe,
  // receive stream to the user
  output gmp_byte_t       rx_data,
  output logic            rx_valid,
  output logic            rx_error,
  output logic            partner_lpi,
  output logic            carrier,
  output logic            collision
);

  gmp_mac_st_t  st_r;
  gmp_mac_st_t  st_nxt;
  gmp_mac_syn_t pins;
  logic         wrap;
  logic         launch;
  logic         rx_take;

  assign pins = {link.rx_clk, link.tx_clk, link.crs, link.col, link.rx_er, link.rx_dv, link.rxd};

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.syn1 = pins;
    st_nxt.syn2 = st_r.syn1;
    st_nxt.syn3 = st_r.syn2;
    st_nxt.filt = gmp_filt(st_r.syn2, st_r.syn3, st_r.filt);
    st_nxt.rxc_prev = st_r.filt[`GMP_MAC_RXCLK_BIT];
    st_nxt.txc_prev = st_r.filt[`GMP_MAC_TXCLK_BIT];

    wrap = gmp_div_wrap(st_r.div_cnt);
    st_nxt.div_cnt = wrap ? '0 : st_r.div_cnt + 1'b1;
    if (wrap)
    begin
      st_nxt.gtx_clk = gmii_mode & ~st_r.gtx_clk;
    end

    // gmii: launch on own falling gtx edge; mii: on the device's rising tx_clk
    launch = gmii_mode ? (wrap & st_r.gtx_clk)
                       : (st_r.filt[`GMP_MAC_TXCLK_BIT] & ~st_r.txc_prev);
    st_nxt.tx_strobe = 1'b0;
    if (launch)
    begin
      st_nxt.txd       = gmp_lane(gmii_mode, frame_data);
      st_nxt.tx_en     = frame_valid;
      st_nxt.tx_er     = frame_valid ? frame_err : lpi_request;
      st_nxt.tx_strobe = 1'b1;
    end

    rx_take = st_r.filt[`GMP_MAC_RXCLK_BIT] & ~st_r.rxc_prev;
    st_nxt.rx_valid = 1'b0;
    st_nxt.rx_error = 1'b0;
    if (rx_take)
    begin
      st_nxt.rx_valid    = st_r.filt[`GMP_MAC_RXDV_BIT];
      st_nxt.rx_data     = gmp_lane(gmii_mode, st_r.filt[`GMP_BYTE_W-1:0]);
      st_nxt.rx_error    = st_r.filt[`GMP_MAC_RXDV_BIT] & st_r.filt[`GMP_MAC_RXER_BIT];
      st_nxt.partner_lpi = ~st_r.filt[`GMP_MAC_RXDV_BIT] & st_r.filt[`GMP_MAC_RXER_BIT];
    end
    st_nxt.carrier   = st_r.filt[`GMP_MAC_CRS_BIT];
    st_nxt.collision = st_r.filt[`GMP_MAC_COL_BIT];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign link.txd    = st_r.txd;
  assign link.tx_en  = st_r.tx_en;
  assign link.tx_er  = st_r.tx_er;
  assign link.gtx_clk = st_r.gtx_clk;
  assign tx_strobe   = st_r.tx_strobe;
  assign rx_data     = st_r.rx_data;
  assign rx_valid    = st_r.rx_valid;
  assign rx_error    = st_r.rx_error;
  assign partner_lpi = st_r.partner_lpi;
  assign carrier     = st_r.carrier;
  assign collision   = st_r.collision;

endmodule

`default_nettype wire

// ===== verilog/gmp_phy_end.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmp_consts.svh"

module gmp_phy_end
  import gmp_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // link toward the mac
  gmp_link_if.phy         link,
  // mode
  input  wire logic       gmii_mode,
  input  wire logic       half_duplex,
  input  wire logic       crossover,
  // media receive side
  input  wire logic       media_rx_valid,
  input  wire gmp_byte_t  media_rx_data,
  input  wire logic       media_rx_err,
  input  wire logic       partner_lpi,
  input  wire logic       carrier_in,
  input  wire logic       collision_in,
  output logic            rx_strobe,
  // media transmit side
  output gmp_byte_t       tx_data,
  output logic            tx_valid,
  output logic            tx_error,
  output logic            tx_sof,
  output logic            tx_eof,
  output logic            lpi_req,
  // media pair roles, bit 0 = pair a .. bit 3 = pair d
  output gmp_pairs_t      pair_tx,
  output gmp_pairs_t      pair_rx
);

  // --------------------------------------------------------------------------
  // state and decode
  // --------------------------------------------------------------------------
  gmp_phy_st_t  st_r;
  gmp_phy_st_t  st_nxt;
  gmp_phy_syn_t pins;
  gmp_phy_syn_t dif;
  logic         wrap;
  logic         rise;
  logic         fall;
  logic         tx_take;
  logic         in_en;
  logic         in_er;

  // --------------------------------------------------------------------------
  // pins from the mac
  // --------------------------------------------------------------------------
  // every bit passes the same stages, so a word settles as one
  assign pins = {link.gtx_clk, link.tx_er, link.tx_en, link.txd};

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;

    // ------------------------------------------------------------------------
    // three stage synchroniser on every pin from the mac
    // ------------------------------------------------------------------------
    st_nxt.syn1 = pins;
    st_nxt.syn2 = st_r.syn1;
    st_nxt.syn3 = st_r.syn2;
    dif         = st_r.syn2 ^ st_r.syn3;
    st_nxt.filt = (st_r.syn2 & ~dif) | (st_r.filt & dif);
    st_nxt.gtx_prev = st_r.filt[`GMP_PHY_GTX_BIT];

    // ------------------------------------------------------------------------
    // own link clocks
    // ------------------------------------------------------------------------
    // rx_clk always runs, tx_clk only in mii
    wrap = gmp_div_wrap(st_r.div_cnt);
    rise = wrap & ~st_r.rx_clk;
    fall = wrap & st_r.rx_clk;
    st_nxt.div_cnt = wrap ? '0 : st_r.div_cnt + 1'b1;
    if (wrap)
    begin
      st_nxt.rx_clk = ~st_r.rx_clk;
      st_nxt.tx_clk = ~st_r.rx_clk & ~gmii_mode;
    end

    // ------------------------------------------------------------------------
    // transmit capture
    // ------------------------------------------------------------------------
    // gtx is ignored in mii; mii samples at our own rising tx_clk, so the
    // mac has a whole period to answer through both synchronisers
    tx_take = gmii_mode ? (st_r.filt[`GMP_PHY_GTX_BIT] & ~st_r.gtx_prev) : rise;
    in_en   = st_r.filt[`GMP_PHY_TXEN_BIT];
    in_er   = st_r.filt[`GMP_PHY_TXER_BIT];

    // tx_data keeps its last octet; only tx_valid marks it fresh
    st_nxt.tx_valid = 1'b0;
    st_nxt.tx_error = 1'b0;
    st_nxt.tx_sof   = 1'b0;
    st_nxt.tx_eof   = 1'b0;
    if (tx_take)
    begin
      if (in_en)
      begin
        st_nxt.tx_valid = 1'b1;
        st_nxt.tx_data  = gmp_lane(gmii_mode, st_r.filt[`GMP_BYTE_W-1:0]);
        st_nxt.tx_error = in_er;
        st_nxt.tx_sof   = ~st_r.tx_in_frame;
        st_nxt.lpi_req  = 1'b0;
      end
      else
      begin
        st_nxt.tx_eof  = st_r.tx_in_frame;
        st_nxt.lpi_req = in_er;
      end
      st_nxt.tx_in_frame = in_en;
    end

    // ------------------------------------------------------------------------
    // receive launch on falling rx_clk, stable at the mac's rising edge
    // ------------------------------------------------------------------------
    // lpi shows on rx_er only while rx_dv is low
    st_nxt.rx_strobe = 1'b0;
    if (fall)
    begin
      st_nxt.rxd       = gmp_lane(gmii_mode, media_rx_data);
      st_nxt.rx_dv     = media_rx_valid;
      st_nxt.rx_er     = media_rx_valid ? media_rx_err : partner_lpi;
      st_nxt.crs       = half_duplex & carrier_in;
      st_nxt.col       = half_duplex & collision_in;
      st_nxt.rx_strobe = 1'b1;
    end

    // ------------------------------------------------------------------------
    // media pair roles
    // ------------------------------------------------------------------------
    // follows the mode pins every cycle; a swap mid-frame is not guarded
    if (gmii_mode)
    begin
      st_nxt.pair_tx = `GMP_PAIRS_ALL;
      st_nxt.pair_rx = `GMP_PAIRS_ALL;
    end
    else if (crossover)
    begin
      st_nxt.pair_tx = `GMP_PAIR_SECOND;
      st_nxt.pair_rx = `GMP_PAIR_FIRST;
    end
    else
    begin
      st_nxt.pair_tx = `GMP_PAIR_FIRST;
      st_nxt.pair_rx = `GMP_PAIR_SECOND;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // one register for the whole struct keeps every output a flop
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign link.tx_clk = st_r.tx_clk;
  assign link.rx_clk = st_r.rx_clk;
  assign link.rxd    = st_r.rxd;
  assign link.rx_dv  = st_r.rx_dv;
  assign link.rx_er  = st_r.rx_er;
  assign link.crs    = st_r.crs;
  assign link.col    = st_r.col;
  assign rx_strobe   = st_r.rx_strobe;
  assign tx_data     = st_r.tx_data;
  assign tx_valid    = st_r.tx_valid;
  assign tx_error    = st_r.tx_error;
  assign tx_sof      = st_r.tx_sof;
  assign tx_eof      = st_r.tx_eof;
  assign lpi_req     = st_r.lpi_req;
  assign pair_tx     = st_r.pair_tx;
  assign pair_rx     = st_r.pair_rx;

endmodule

`default_nettype wire

// ===== tb/gmp_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

`include "gmp_consts.svh"

module gmp_link_asserts (
  // clock, reset, mode
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  input wire logic                   gmii_mode,
  input wire logic                   half_duplex,
  // link
  input wire logic [`GMP_BYTE_W-1:0] txd,
  input wire logic                   tx_en,
  input wire logic                   tx_er,
  input wire logic                   gtx_clk,
  input wire logic                   tx_clk,
  input wire logic                   col,
  input wire logic                   crs,
  input wire logic [`GMP_BYTE_W-1:0] rxd,
  input wire logic                   rx_dv,
  input wire logic                   rx_er,
  input wire logic                   rx_clk
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // link clocks
  // ---------------------------------------------------------------
  rx_clk_period_a: assert property ($changed(rx_clk) |=> $stable(rx_clk)[*7] ##1 $changed(rx_clk))
    else $error("rx_clk half period wrong");
  gtx_high_time_a: assert property ($rose(gtx_clk) |=> gtx_clk[*7] ##1 !gtx_clk)
    else $error("gtx_clk high time wrong");
  tx_clk_period_a: assert property ($rose(tx_clk) |-> ##8 $fell(tx_clk))
    else $error("tx_clk high time wrong");
  gtx_idle_mii_a: assert property (!gmii_mode |-> !gtx_clk)
    else $error("gtx_clk runs in mii");
  tx_clk_idle_a: assert property (gmii_mode |-> !tx_clk)
    else $error("tx_clk runs in gmii");

  // ---------------------------------------------------------------
  // launch edges and lanes
  // ---------------------------------------------------------------
  rx_launch_edge_a: assert property ($changed({rxd, rx_dv, rx_er, crs, col}) |-> $fell(rx_clk))
    else $error("receive pins change off rx_clk fall");
  gmii_tx_launch_a: assert property (gmii_mode && $changed({txd, tx_en, tx_er}) |-> $fell(gtx_clk))
    else $error("gmii transmit pins change off gtx_clk fall");
  mii_tx_launch_a: assert property (!gmii_mode && $changed({txd, tx_en, tx_er}) |-> tx_clk)
    else $error("mii transmit pins change while tx_clk low");
  mii_rx_nibble_a: assert property (!gmii_mode |-> rxd[7:4] == 4'h0)
    else $error("rxd upper nibble set in mii");
  mii_tx_nibble_a: assert property (!gmii_mode |-> txd[7:4] == 4'h0)
    else $error("txd upper nibble set in mii");
  full_duplex_quiet_a: assert property (!half_duplex |-> !crs && !col)
    else $error("crs or col in full duplex");

  cover property ($rose(rx_dv));
  cover property ($rose(tx_en) && tx_er);
  cover property (crs && rx_dv);
  cover property (!gmii_mode && $rose(tx_clk));
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
  import gmp_pkg::*;
;
  localparam logic [11:0] idle_lpi = 12'h400;

  logic        ref_clk, nrst, gm, hd, xo, prev_v;
  logic [11:0] txi, rxi;
  logic [11:0] txq[$], rxq[$];
  logic [9:0]  etx[$], et;
  logic [10:0] erx[$], er;
  logic [31:0] seed;
  int          miscompares, n_compared, eofs;
  logic        tx_strobe, tx_valid, tx_error, tx_sof, tx_eof, lpi_req, rx_strobe;
  logic        rx_valid, rx_error, partner_lpi, carrier, collision;
  gmp_byte_t   tx_data, rx_data;
  gmp_pairs_t  pair_tx, pair_rx;

  gmp_link_if lnk();

  gmp_phy_end i_gmp_phy_end (.ref_clk(ref_clk), .nrst(nrst), .link(lnk.phy), .gmii_mode(gm), .half_duplex(hd),
    .crossover(xo), .media_rx_valid(rxi[11]), .media_rx_data(rxi[7:0]), .media_rx_err(rxi[11] & rxi[10]),
    .partner_lpi(!rxi[11] & rxi[10]), .carrier_in(rxi[9]), .collision_in(rxi[8]), .rx_strobe(rx_strobe),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_error(tx_error), .tx_sof(tx_sof), .tx_eof(tx_eof),
    .lpi_req(lpi_req), .pair_tx(pair_tx), .pair_rx(pair_rx));

  gmp_mac_end i_gmp_mac_end (.ref_clk(ref_clk), .nrst(nrst), .link(lnk.mac), .gmii_mode(gm),
    .frame_valid(txi[11]), .frame_data(txi[7:0]), .frame_err(txi[11] & txi[10]),
    .lpi_request(!txi[11] & txi[10]), .tx_strobe(tx_strobe), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_error(rx_error), .partner_lpi(partner_lpi), .carrier(carrier), .collision(collision));

  gmp_link_asserts i_gmp_link_asserts (.ref_clk(ref_clk), .nrst(nrst), .gmii_mode(gm), .half_duplex(hd),
    .txd(lnk.txd), .tx_en(lnk.tx_en), .tx_er(lnk.tx_er), .gtx_clk(lnk.gtx_clk), .tx_clk(lnk.tx_clk),
    .col(lnk.col), .crs(lnk.crs), .rxd(lnk.rxd), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er), .rx_clk(lnk.rx_clk));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [7:0] lane(input logic [7:0] d);
    return gm ? d : {4'h0, d[3:0]};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // feed on strobes, model, compare
  // ---------------------------------------------------------------
  // items: {valid, err, crs, col, data}; once drained, idle with lpi
  always @(posedge ref_clk)
  begin
    if (tx_strobe)
    begin
      if (txi[11])
        etx.push_back({!prev_v, txi[10], lane(txi[7:0])});
      prev_v = txi[11];
      txi <= txq.size() ? txq.pop_front() : idle_lpi;
    end
    if (rx_strobe)
    begin
      if (rxi[11])
        erx.push_back({rxi[10], rxi[9:8] & {2{hd}}, lane(rxi[7:0])});
      rxi <= rxq.size() ? rxq.pop_front() : idle_lpi;
    end
    if (tx_valid)
    begin
      et = etx.size() ? etx.pop_front() : 'x;
      chk("tx_data", tx_data, et[7:0]);
      chk("tx_error", tx_error, et[8]);
      chk("tx_sof", tx_sof, et[9]);
      chk("lpi_req", lpi_req, 0);
    end
    if (rx_valid)
    begin
      er = erx.size() ? erx.pop_front() : 'x;
      chk("rx_data", rx_data, er[7:0]);
      chk("rx_error", rx_error, er[10]);
      chk("carrier", carrier, er[9]);
      chk("collision", collision, er[8]);
      chk("partner_lpi", partner_lpi, 0);
    end
    if (tx_eof)
      eofs++;
  end

  // ---------------------------------------------------------------
  // one mode setting: two frames each way, error on a middle and a last octet
  // ---------------------------------------------------------------
  task automatic phase(input logic g, input logic h, input logic x);
    nrst <= 1'b0;
    gm <= g;
    hd <= h;
    xo <= x;
    // wait an edge so no strobe from the old run lands in fresh queues
    @(posedge ref_clk);
    txq.delete();
    rxq.delete();
    etx.delete();
    erx.delete();
    eofs = 0;
    prev_v = 0;
    for (int i = 0; i < 9; i++)
    begin
      seed = xs(seed);
      txq.push_back({i != 5, i == 1 || i == 8, 2'b00, seed[7:0]});
      rxq.push_back({i != 5, i == 1 || i == 8, seed[17:8]});
    end
    txi <= txq.pop_front();
    rxi <= rxq.pop_front();
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("pair_tx", pair_tx, g ? 4'hF : x ? 4'h2 : 4'h1);
    chk("pair_rx", pair_rx, g ? 4'hF : x ? 4'h1 : 4'h2);
    for (int k = 0; k < 1000 && txq.size() + rxq.size() + etx.size() + erx.size() > 0; k++)
      @(posedge ref_clk);
    repeat (64) @(posedge ref_clk);
    chk("leftover", txq.size() + rxq.size() + etx.size() + erx.size(), 0);
    chk("tx_eof", eofs, 2);
    chk("lpi_req", lpi_req, 1);
    chk("partner_lpi", partner_lpi, 1);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    nrst = 1'b0;
    gm = 1'b1;
    hd = 1'b0;
    xo = 1'b0;
    txi = idle_lpi;
    rxi = idle_lpi;
    seed = 96;
    miscompares = 0;
    n_compared = 0;
    @(posedge ref_clk);
    phase(1'b1, 1'b1, 1'b0);
    phase(1'b0, 1'b1, 1'b0);
    phase(1'b0, 1'b0, 1'b1);
    results();
  end

  // three runs of a few hundred cycles each
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    results();
  end
endmodule

`default_nettype wire
